// *** hdl/dctw_watchdog_top.sv ***
// dctw_watchdog_top: one channel of the dual channel timing watchdog with its
// processor clocks, tick interrupt, window watchdog, clock checker, the shared
// memory to the communications processor and the cross-channel exchange memory.
// assumes core_clk is the common master oscillator; processor ports are logic
// on core_clk; the watchdog oscillator and the prime strap are raw pins.
`timescale 1ns/1ps

module dctw_watchdog_top #(
  parameter int TICK_CYCLES  = dctw_pkg::TICK_CYCLES,
  parameter int WD_OSC_HZ    = dctw_pkg::WD_OSC_HZ_DEF,
  parameter int WIN_PERIOD   = int'(dctw_pkg::WD_OSC_HZ_DEF / 1000
                                    * dctw_pkg::WINDOW_PERIOD_MS),
  parameter int WIN_WIDTH    = dctw_pkg::WINDOW_WIDTH_DEF,
  parameter int FREQ_TOL     = dctw_pkg::FREQ_TOL_DEF,
  parameter int AW           = dctw_pkg::MEM_AW,
  parameter int DW           = dctw_pkg::MEM_WIDTH
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  // pins
  input  wire logic          primeStrapPin,
  input  wire logic          wdOscPin,
  // processor clocks and tick
  output logic               mainProcClk,
  output logic               commProcClk,
  output logic               tickIrq,
  input  wire logic          tickAck,
  // watchdog
  input  wire logic          punchIn,
  output logic               holdOff,
  output logic               holdOffDrive,
  output logic               windowOpen,
  output logic               wdFault,
  output logic               clkFault,
  output logic               isPrime,
  // shared memory, main processor port
  input  wire logic          smMainReq,
  input  wire logic          smMainWe,
  input  wire logic [AW-1:0] smMainAddr,
  input  wire logic [DW-1:0] smMainWdata,
  output logic      [DW-1:0] smMainRdata,
  output logic               smMainAck,
  output logic               smMainNewData,
  // shared memory, communications processor port
  input  wire logic          smCommReq,
  input  wire logic          smCommWe,
  input  wire logic [AW-1:0] smCommAddr,
  input  wire logic [DW-1:0] smCommWdata,
  output logic      [DW-1:0] smCommRdata,
  output logic               smCommAck,
  output logic               smCommNewData,
  // exchange memory, local main processor port
  input  wire logic          xmLocReq,
  input  wire logic          xmLocWe,
  input  wire logic [AW-1:0] xmLocAddr,
  input  wire logic [DW-1:0] xmLocWdata,
  output logic      [DW-1:0] xmLocRdata,
  output logic               xmLocAck,
  // exchange memory, remote main processor port
  input  wire logic          xmRemReq,
  input  wire logic [AW-1:0] xmRemAddr,
  output logic      [DW-1:0] xmRemRdata,
  output logic               xmRemAck,
  output logic               xmRemNewData
);

  localparam int WCW       = $clog2(WIN_PERIOD + 1);
  localparam int TCW       = $clog2(TICK_CYCLES + 1);
  localparam int EXP_EDGES = WD_OSC_HZ / 100;
  localparam int ECW       = $clog2(EXP_EDGES + FREQ_TOL + 2);
  localparam int DEAD_CYC  = int'(dctw_pkg::CORE_CLK_HZ / WD_OSC_HZ)
                             * dctw_pkg::WD_DEAD_PERIODS;
  localparam int DCW       = $clog2(DEAD_CYC + 2);

  logic [dctw_pkg::NCO_W-1:0] nco_r;
  logic                       halfTick;
  logic                       procClk_r;
  logic [2:0]                 strapSync_r;
  logic                       strapLocked_r;
  logic [1:0]                 strapFill_r;
  logic [2:0]                 oscSync_r;
  logic                       oscFilt_r;
  logic                       oscEdge;
  logic [TCW-1:0]             tickCnt_r;
  logic                       tick;
  logic [WCW-1:0]             winCnt_r;
  logic                       winClose;
  logic                       punchSeen_r;
  dctw_pkg::dctw_wd_state_t   state_r;
  dctw_pkg::dctw_wd_state_t   state_nxt;
  logic [DCW-1:0]             deadCnt_r;
  logic [ECW-1:0]             edgeCnt_r;
  logic                       healthy;
  logic                       mainPhase;

  // processor clock: phase accumulator keeps the 4 MHz average to within the truncation of NCO_INC even
  // though 125 MHz is no integer multiple; edges jitter by one core cycle
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      nco_r    <= '0;
      halfTick <= 1'b0;
    end
    else
    begin
      {halfTick, nco_r} <= {1'b0, nco_r} + {1'b0, dctw_pkg::NCO_INC};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      procClk_r   <= 1'b0;
      mainProcClk <= 1'b0;
      commProcClk <= 1'b1;
    end
    else if (halfTick)
    begin
      procClk_r   <= !procClk_r;
      mainProcClk <= isPrime ? !procClk_r : procClk_r;
      commProcClk <= isPrime ? procClk_r : !procClk_r;
    end
  end

  // strap is latched once, after all three stages hold the pin and the last
  // two agree; the reset value of the stages must never be taken as the strap
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strapSync_r   <= '0;
      strapFill_r   <= '0;
      strapLocked_r <= 1'b0;
      isPrime       <= 1'b0;
    end
    else
    begin
      strapSync_r <= {strapSync_r[1:0], primeStrapPin};
      if (strapFill_r != 2'h3)
        strapFill_r <= strapFill_r + 2'h1;
      if (!strapLocked_r && (strapFill_r == 2'h3) && (strapSync_r[1] == strapSync_r[2]))
      begin
        strapLocked_r <= 1'b1;
        isPrime       <= strapSync_r[2];
      end
    end
  end

  // watchdog oscillator pin: counts a rising edge once stages two and three agree
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oscSync_r <= '0;
      oscFilt_r <= 1'b0;
      oscEdge   <= 1'b0;
    end
    else
    begin
      oscSync_r <= {oscSync_r[1:0], wdOscPin};
      oscEdge   <= 1'b0;
      if (oscSync_r[1] == oscSync_r[2])
      begin
        oscFilt_r <= oscSync_r[2];
        oscEdge   <= oscSync_r[2] && !oscFilt_r;
      end
    end
  end

  // 100 Hz tick from the master clock
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tickCnt_r <= '0;
      tick      <= 1'b0;
    end
    else
    begin
      tick <= (tickCnt_r == TCW'(TICK_CYCLES - 1));
      if (tickCnt_r == TCW'(TICK_CYCLES - 1))
        tickCnt_r <= '0;
      else
        tickCnt_r <= tickCnt_r + 1'b1;
    end
  end

  // interrupt holds until acknowledged; a new tick wins over the ack
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      tickIrq <= 1'b0;
    else if (tick)
      tickIrq <= 1'b1;
    else if (tickAck)
      tickIrq <= 1'b0;
  end

  // acceptance window: the last WIN_WIDTH edges of each period
  assign winClose = oscEdge && (winCnt_r == WCW'(WIN_PERIOD - 1));

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      winCnt_r   <= '0;
      windowOpen <= 1'b0;
    end
    else if (oscEdge)
    begin
      if (winCnt_r == WCW'(WIN_PERIOD - 1))
        winCnt_r <= '0;
      else
        winCnt_r <= winCnt_r + 1'b1;
      windowOpen <= (winCnt_r >= WCW'(WIN_PERIOD - WIN_WIDTH - 1))
                    && (winCnt_r != WCW'(WIN_PERIOD - 1));
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      punchSeen_r <= 1'b0;
    else if (winClose)
      punchSeen_r <= 1'b0;
    else if (punchIn && windowOpen)
      punchSeen_r <= 1'b1;
  end

  // arming lets software find the window before hold-off is first given
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      // a punch in the closing cycle still belongs to the window that ends
      dctw_pkg::DCTW_ARMING:
        if (winClose && (punchSeen_r || punchIn))
          state_nxt = dctw_pkg::DCTW_RUNNING;
      dctw_pkg::DCTW_RUNNING:
        if ((punchIn && (!windowOpen || punchSeen_r)) || (winClose && !punchSeen_r && !punchIn))
          state_nxt = dctw_pkg::DCTW_TRIPPED;
      dctw_pkg::DCTW_TRIPPED:
        state_nxt = dctw_pkg::DCTW_TRIPPED;
      default:
        state_nxt = dctw_pkg::DCTW_TRIPPED;
    endcase
    if (clkFault)
      state_nxt = dctw_pkg::DCTW_TRIPPED;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= dctw_pkg::DCTW_ARMING;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      wdFault <= 1'b0;
    else if (state_r == dctw_pkg::DCTW_TRIPPED)
      wdFault <= 1'b1;
  end

  // clock checker: a silent watchdog oscillator, or an edge count per tick
  // outside tolerance, means one of the two oscillators has failed or drifted
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      deadCnt_r <= '0;
      edgeCnt_r <= '0;
      clkFault  <= 1'b0;
    end
    else
    begin
      if (oscEdge)
        deadCnt_r <= '0;
      else if (deadCnt_r != DCW'(DEAD_CYC))
        deadCnt_r <= deadCnt_r + 1'b1;
      if (deadCnt_r == DCW'(DEAD_CYC))
        clkFault <= 1'b1;
      if (tick)
      begin
        edgeCnt_r <= ECW'(oscEdge);
        if ((edgeCnt_r < ECW'(EXP_EDGES - FREQ_TOL))
            || (edgeCnt_r > ECW'(EXP_EDGES + FREQ_TOL)))
          clkFault <= 1'b1;
      end
      else if (oscEdge && (edgeCnt_r != ECW'(EXP_EDGES + FREQ_TOL + 1)))
        edgeCnt_r <= edgeCnt_r + 1'b1;
      else if (edgeCnt_r == ECW'(EXP_EDGES + FREQ_TOL + 1))
        clkFault <= 1'b1;
    end
  end

  // hold-off is also a toggling drive: if the master clock stops, the
  // brake circuit sees the toggling stop even though the level is frozen
  assign healthy = (state_r == dctw_pkg::DCTW_RUNNING) && !clkFault;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      holdOff      <= 1'b0;
      holdOffDrive <= 1'b0;
    end
    else
    begin
      holdOff <= healthy;
      if (!healthy)
        holdOffDrive <= 1'b0;
      else if (halfTick)
        holdOffDrive <= !holdOffDrive;
    end
  end

  // main processor owns the half cycle in which its own clock is high
  assign mainPhase = mainProcClk;

  dctw_dual_port_mem #(
    .DEPTH       (dctw_pkg::MEM_DEPTH),
    .WIDTH       (DW),
    .AW          (AW),
    .B_READ_ONLY (1'b0)
  ) u_shared_mem (
    .clk      (core_clk),
    .reset_n  (reset_n),
    .prioA    (mainPhase),
    .aReq     (smMainReq),
    .aWe      (smMainWe),
    .aWrAllow (1'b1),
    .aAddr    (smMainAddr),
    .aWdata   (smMainWdata),
    .aRdata   (smMainRdata),
    .aAck     (smMainAck),
    .aNewData (smMainNewData),
    .bReq     (smCommReq),
    .bWe      (smCommWe),
    .bAddr    (smCommAddr),
    .bWdata   (smCommWdata),
    .bRdata   (smCommRdata),
    .bAck     (smCommAck),
    .bNewData (smCommNewData)
  );

  dctw_dual_port_mem #(
    .DEPTH       (dctw_pkg::MEM_DEPTH),
    .WIDTH       (DW),
    .AW          (AW),
    .B_READ_ONLY (1'b1)
  ) u_exchange_mem (
    .clk      (core_clk),
    .reset_n  (reset_n),
    .prioA    (mainPhase),
    .aReq     (xmLocReq),
    .aWe      (xmLocWe),
    .aWrAllow (healthy),
    .aAddr    (xmLocAddr),
    .aWdata   (xmLocWdata),
    .aRdata   (xmLocRdata),
    .aAck     (xmLocAck),
    .aNewData (),
    .bReq     (xmRemReq),
    .bWe      (1'b0),
    .bAddr    (xmRemAddr),
    .bWdata   ('0),
    .bRdata   (xmRemRdata),
    .bAck     (xmRemAck),
    .bNewData (xmRemNewData)
  );

endmodule : dctw_watchdog_top

// *** inc/dctw_pkg.sv ***
// dctw_pkg: constants and types for the dual channel timing watchdog.
// assumes a 125 MHz core clock that is the master oscillator of the channel.
package dctw_pkg;

  // clocking
  localparam longint CORE_CLK_HZ       = 125_000_000;
  localparam longint PROC_CLK_HZ       = 4_000_000;
  localparam int     NCO_W             = 32;
  // accumulator step for one edge per half period of the processor clock
  localparam logic [NCO_W-1:0] NCO_INC =
    NCO_W'(((2 * PROC_CLK_HZ) << NCO_W) / CORE_CLK_HZ);

  // periodic interrupt
  localparam longint TICK_PERIOD_MS    = 10;
  localparam int     TICK_CYCLES       = int'(CORE_CLK_HZ / 1000 * TICK_PERIOD_MS);

  // acceptance window, counted in watchdog oscillator edges
  localparam longint WINDOW_PERIOD_MS  = 40;
  localparam int     WD_OSC_HZ_DEF     = 1_000_000;
  localparam int     WINDOW_WIDTH_DEF  = 100;
  localparam int     FREQ_TOL_DEF      = 4;
  // watchdog oscillator periods without an edge before the oscillator counts as dead
  localparam int     WD_DEAD_PERIODS   = 4;

  // memories
  localparam int     MEM_DEPTH         = 1024;
  localparam int     MEM_WIDTH         = 16;
  localparam int     MEM_AW            = 10;

  // watchdog states
  typedef enum logic [1:0] {
    DCTW_ARMING,
    DCTW_RUNNING,
    DCTW_TRIPPED
  } dctw_wd_state_t;

endpackage : dctw_pkg

// *** hdl/dctw_dual_port_mem.sv ***
// dctw_dual_port_mem: two-port word memory with per-cycle arbitration and
// notify flags. assumes both ports are driven from logic on core_clk.
`timescale 1ns/1ps

module dctw_dual_port_mem #(
  parameter int DEPTH       = dctw_pkg::MEM_DEPTH,
  parameter int WIDTH       = dctw_pkg::MEM_WIDTH,
  parameter int AW          = dctw_pkg::MEM_AW,
  parameter bit B_READ_ONLY = 1'b0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // arbitration phase: high gives port a the first claim
  input  wire logic             prioA,
  // port a
  input  wire logic             aReq,
  input  wire logic             aWe,
  input  wire logic             aWrAllow,
  input  wire logic [AW-1:0]    aAddr,
  input  wire logic [WIDTH-1:0] aWdata,
  output logic      [WIDTH-1:0] aRdata,
  output logic                  aAck,
  output logic                  aNewData,
  // port b
  input  wire logic             bReq,
  input  wire logic             bWe,
  input  wire logic [AW-1:0]    bAddr,
  input  wire logic [WIDTH-1:0] bWdata,
  output logic      [WIDTH-1:0] bRdata,
  output logic                  bAck,
  output logic                  bNewData
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic             grantA;
  logic             grantB;
  logic             wrA;
  logic             wrB;

  // the losing port just keeps its request up and wins once the other port drops its request or prioA turns
  assign grantA = aReq && (prioA || !bReq);
  assign grantB = bReq && !grantA;
  assign wrA    = grantA && aWe && aWrAllow;
  assign wrB    = grantB && bWe && !B_READ_ONLY;

  always_ff @(posedge clk)
  begin
    if (wrA)
      mem[aAddr] <= aWdata;
    else if (wrB)
      mem[bAddr] <= bWdata;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aRdata <= '0;
      bRdata <= '0;
      aAck   <= 1'b0;
      bAck   <= 1'b0;
    end
    else
    begin
      aAck <= grantA;
      bAck <= grantB;
      if (grantA)
        aRdata <= mem[aAddr];
      if (grantB)
        bRdata <= mem[bAddr];
    end
  end

  // notify flags: a write by one side raises the other side's flag, its read
  // clears it; the raise wins over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aNewData <= 1'b0;
      bNewData <= 1'b0;
    end
    else
    begin
      if (wrB)
        aNewData <= 1'b1;
      else if (grantA && !aWe)
        aNewData <= 1'b0;
      if (wrA)
        bNewData <= 1'b1;
      else if (grantB && !bWe)
        bNewData <= 1'b0;
    end
  end

endmodule : dctw_dual_port_mem

// *** bench/dctw_watchdog_monitor.sv ***
// dctw_watchdog_monitor: port assertions for one watchdog channel.
// assumes every port is sampled on the rising edge of core_clk.
`timescale 1ns/1ps

module dctw_watchdog_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // clocks, tick and safety outputs
  input wire logic mainProcClk,
  input wire logic commProcClk,
  input wire logic tickIrq,
  input wire logic tickAck,
  input wire logic holdOff,
  input wire logic wdFault,
  input wire logic clkFault,
  // memory handshakes
  input wire logic smMainReq,
  input wire logic smMainAck,
  input wire logic smCommReq,
  input wire logic smCommAck,
  input wire logic xmLocReq,
  input wire logic xmLocAck,
  input wire logic xmRemReq,
  input wire logic xmRemAck
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // port a holds the first claim while the main clock phase is high
  sequence s_main_wins; smMainReq && mainProcClk; endsequence
  sequence s_comm_wins; smCommReq && !(smMainReq && mainProcClk); endsequence

  property p_clk_compl; commProcClk == !mainProcClk; endproperty
  property p_tick_hold; tickIrq && !tickAck |=> tickIrq; endproperty
  property p_wd_sticky; wdFault |=> wdFault; endproperty
  property p_wd_safe; wdFault |-> !holdOff; endproperty
  property p_clk_sticky; clkFault |=> clkFault; endproperty
  property p_clk_safe; clkFault |-> ##2 !holdOff; endproperty
  property p_sm_main; s_main_wins |=> smMainAck; endproperty
  property p_sm_comm; s_comm_wins |=> smCommAck; endproperty
  property p_xm_loc; xmLocReq && mainProcClk |=> xmLocAck; endproperty
  property p_xm_rem; xmRemReq |-> ##[1:3] xmRemAck; endproperty

  a_clk_compl : assert property (p_clk_compl) else $error("clock pair not inverse");
  a_tick_hold : assert property (p_tick_hold) else $error("tick dropped unacked");
  a_wd_sticky : assert property (p_wd_sticky) else $error("wd fault cleared");
  a_wd_safe : assert property (p_wd_safe) else $error("hold-off with wd fault");
  a_clk_sticky : assert property (p_clk_sticky) else $error("clk fault cleared");
  a_clk_safe : assert property (p_clk_safe) else $error("hold-off with clk fault");
  a_sm_main : assert property (p_sm_main) else $error("main port not served");
  a_sm_comm : assert property (p_sm_comm) else $error("comm port not served");
  a_xm_loc : assert property (p_xm_loc) else $error("local port not served");
  a_xm_rem : assert property (p_xm_rem) else $error("remote port starved");
endmodule : dctw_watchdog_monitor

bind dctw_watchdog_top dctw_watchdog_monitor u_mon (
  .core_clk(core_clk), .reset_n(reset_n), .mainProcClk(mainProcClk),
  .commProcClk(commProcClk), .tickIrq(tickIrq), .tickAck(tickAck), .holdOff(holdOff),
  .wdFault(wdFault), .clkFault(clkFault), .smMainReq(smMainReq), .smMainAck(smMainAck),
  .smCommReq(smCommReq), .smCommAck(smCommAck), .xmLocReq(xmLocReq), .xmLocAck(xmLocAck),
  .xmRemReq(xmRemReq), .xmRemAck(xmRemAck)
);

// *** bench/dctw_proc_model.sv ***
// dctw_proc_model: main processor punch logic and watchdog oscillator.
// assumes the oscillator period is 8 core cycles; modes set by the bench.
`timescale 1ns/1ps

module dctw_proc_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // bench control: 0 good, 1 silent, 2 extra punch outside the window
  input  wire logic [1:0] punchMode,
  input  wire logic       oscRun,
  // block side
  input  wire logic       windowOpen,
  output logic            wdOscPin,
  output logic            punchIn
);
  logic [2:0] oscCnt_r;
  logic [7:0] inCnt_r;
  logic [7:0] outCnt_r;

  // a stopped oscillator stands still low, as a dead part would
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      oscCnt_r <= 3'h0;
    else if (oscRun)
      oscCnt_r <= oscCnt_r + 3'h1;
  end
  assign wdOscPin = oscRun & ~oscCnt_r[2];

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      inCnt_r  <= 8'h00;
      outCnt_r <= 8'h00;
      punchIn  <= 1'b0;
    end
    else
    begin
      inCnt_r  <= windowOpen ? inCnt_r + {7'h00, inCnt_r != 8'hFF} : 8'h00;
      outCnt_r <= windowOpen ? 8'h00 : outCnt_r + {7'h00, outCnt_r != 8'hFF};
      punchIn  <= (inCnt_r == 8'h03 && punchMode != 2'h1)
               || (outCnt_r == 8'h32 && punchMode == 2'h2);
    end
  end
endmodule : dctw_proc_model

// *** bench/tb.sv ***
// tb: self-checking bench for one channel of the timing watchdog.
// assumes dctw_proc_model plays the main processor and its oscillator.
`timescale 1ns/1ps

module tb;
  // shortened counts: 25 oscillator edges per tick, 100 per window period
  localparam int TICK = 200;
  localparam int WPER = 100;
  localparam int WWID = 10;
  localparam int WCYC = WPER * 8;
  localparam int AW   = dctw_pkg::MEM_AW;
  localparam int DW   = dctw_pkg::MEM_WIDTH;

  logic          core_clk;
  logic          reset_n;
  logic          primeStrapPin;
  logic          wdOscPin;
  logic          tickAck;
  logic          punchIn;
  logic [1:0]    punchMode;
  logic          oscRun;
  logic          mainProcClk;
  logic          commProcClk;
  logic          tickIrq;
  logic          holdOff;
  logic          hoDrive;
  logic          windowOpen;
  logic          wdFault;
  logic          clkFault;
  logic          isPrime;
  logic          rq [4];
  logic          wr [4];
  logic [AW-1:0] ad [4];
  logic [DW-1:0] wd [4];
  logic [DW-1:0] rd [4];
  logic [3:0]    ack;
  logic [2:0]    nd;
  int            errTotal;
  int            samplesChecked;

  dctw_watchdog_top #(.TICK_CYCLES(TICK), .WD_OSC_HZ(2500), .WIN_PERIOD(WPER),
                      .WIN_WIDTH(WWID)) u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .primeStrapPin(primeStrapPin),
    .wdOscPin(wdOscPin), .mainProcClk(mainProcClk), .commProcClk(commProcClk),
    .tickIrq(tickIrq), .tickAck(tickAck), .punchIn(punchIn), .holdOff(holdOff),
    .holdOffDrive(hoDrive), .windowOpen(windowOpen), .wdFault(wdFault),
    .clkFault(clkFault), .isPrime(isPrime),
    .smMainReq(rq[0]), .smMainWe(wr[0]), .smMainAddr(ad[0]), .smMainWdata(wd[0]),
    .smMainRdata(rd[0]), .smMainAck(ack[0]), .smMainNewData(nd[0]),
    .smCommReq(rq[1]), .smCommWe(wr[1]), .smCommAddr(ad[1]), .smCommWdata(wd[1]),
    .smCommRdata(rd[1]), .smCommAck(ack[1]), .smCommNewData(nd[1]),
    .xmLocReq(rq[2]), .xmLocWe(wr[2]), .xmLocAddr(ad[2]), .xmLocWdata(wd[2]),
    .xmLocRdata(rd[2]), .xmLocAck(ack[2]),
    .xmRemReq(rq[3]), .xmRemAddr(ad[3]), .xmRemRdata(rd[3]), .xmRemAck(ack[3]),
    .xmRemNewData(nd[2])
  );

  dctw_proc_model u_proc (
    .core_clk(core_clk), .reset_n(reset_n), .punchMode(punchMode), .oscRun(oscRun),
    .windowOpen(windowOpen), .wdOscPin(wdOscPin), .punchIn(punchIn)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic testDone;
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : testDone

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      errTotal++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  function automatic logic pick(input int k);
    case (k)
      0: return holdOff;
      1: return windowOpen;
      2: return tickIrq;
      3: return clkFault;
      default: return wdFault;
    endcase
  endfunction : pick

  // a wait that runs out ends the run at once
  task automatic waitLvl(input int k, input logic v, input int lim);
    int n;
    for (n = 0; n < lim && pick(k) !== v; n++)
      @(negedge core_clk);
    if (pick(k) !== v)
    begin
      chk("waitTimeout", k, 32'hFF);
      testDone();
    end
  endtask : waitLvl

  task automatic memOp(input int p, input logic w, input logic [AW-1:0] a,
                       input logic [DW-1:0] d, output logic [DW-1:0] q);
    int n;
    @(negedge core_clk);
    rq[p] = 1'b1;
    wr[p] = w;
    ad[p] = a;
    wd[p] = d;
    for (n = 0; n < 8 && ack[p] !== 1'b1; n++)
      @(negedge core_clk);
    q = rd[p];
    rq[p] = 1'b0;
    if (ack[p] !== 1'b1)
    begin
      chk("memAck", p, 32'hFF);
      testDone();
    end
  endtask : memOp

  task automatic doReset(input logic strap);
    @(negedge core_clk);
    reset_n = 1'b0;
    primeStrapPin = strap;
    punchMode = 2'h0;
    oscRun = 1'b1;
    repeat (20) @(negedge core_clk);
    chk("rstComm", 1, commProcClk);
    reset_n = 1'b1;
    repeat (5) @(negedge core_clk);
    chk("isPrime", strap, isPrime);
  endtask : doReset

  task automatic ackTick;
    tickAck = 1'b1;
    @(negedge core_clk);
    tickAck = 1'b0;
  endtask : ackTick

  task automatic tClocks;
    int n;
    logic prev;
    n = 0;
    prev = mainProcClk;
    repeat (1250)
    begin
      @(negedge core_clk);
      n += int'(mainProcClk & ~prev);
      prev = mainProcClk;
    end
    chk("procClkRises", 1, n >= 39 && n <= 41);
    chk("commProcClk", !mainProcClk, commProcClk);
    ackTick();
    waitLvl(2, 1'b1, TICK + 10);
    ackTick();
    chk("tickCleared", 0, tickIrq);
    for (n = 1; n < 2 * TICK && tickIrq !== 1'b1; n++)
      @(negedge core_clk);
    chk("tickPeriod", TICK, n);
  endtask : tClocks

  task automatic tWindow;
    int n;
    int m;
    logic pv;
    waitLvl(0, 1'b1, 3 * WCYC);
    waitLvl(1, 1'b0, WCYC);
    waitLvl(1, 1'b1, WCYC);
    for (n = 0; n < WCYC && windowOpen === 1'b1; n++)
      @(negedge core_clk);
    for (m = n; m < 2 * WCYC && windowOpen !== 1'b1; m++)
      @(negedge core_clk);
    chk("windowWidth", WWID * 8, n);
    chk("windowPeriod", WCYC, m);
    chk("holdOffKept", 1, holdOff);
    // 250 core cycles hold 16 processor half periods, one short by rounding
    pv = hoDrive;
    m = 0;
    repeat (250)
    begin
      @(negedge core_clk);
      m += int'(hoDrive != pv);
      pv = hoDrive;
    end
    chk("holdOffToggles", 1, m >= 15 && m <= 16);
  endtask : tWindow

  task automatic tMemories;
    logic [DW-1:0] q;
    logic [DW-1:0] q2;
    memOp(0, 1'b1, 10'h3FF, 16'hA5A5, q);
    @(negedge core_clk);
    chk("commNewData", 1, nd[1]);
    memOp(1, 1'b0, 10'h3FF, 16'h0000, q);
    @(negedge core_clk);
    chk("commRead", 16'hA5A5, q);
    chk("commNewDataClr", 0, nd[1]);
    fork
      memOp(0, 1'b1, 10'h000, 16'h1234, q);
      memOp(1, 1'b1, 10'h3FE, 16'h5678, q2);
    join
    chk("mainNewData", 1, nd[0]);
    memOp(1, 1'b0, 10'h000, 16'h0000, q);
    memOp(0, 1'b0, 10'h3FE, 16'h0000, q2);
    chk("collideComm", 16'h1234, q);
    chk("collideMain", 16'h5678, q2);
    memOp(2, 1'b1, 10'h200, 16'hBEEF, q);
    @(negedge core_clk);
    chk("remNewData", 1, nd[2]);
    fork
      memOp(2, 1'b0, 10'h200, 16'h0000, q);
      memOp(3, 1'b0, 10'h200, 16'h0000, q2);
    join
    chk("locRead", 16'hBEEF, q);
    chk("remRead", 16'hBEEF, q2);
  endtask : tMemories

  task automatic tTrip(input logic [1:0] mode);
    logic [DW-1:0] q;
    waitLvl(0, 1'b1, 3 * WCYC);
    punchMode = mode;
    waitLvl(4, 1'b1, 2 * WCYC);
    chk("tripHoldOff", 0, holdOff);
    punchMode = 2'h0;
    repeat (2 * WCYC) @(negedge core_clk);
    chk("holdOffStays", 0, holdOff);
    chk("holdOffDrive", 0, hoDrive);
    memOp(2, 1'b1, 10'h200, 16'h0000, q);
    memOp(3, 1'b0, 10'h200, 16'h0000, q);
    chk("writeRefused", 16'hBEEF, q);
  endtask : tTrip

  task automatic tClkFail;
    doReset(1'b0);
    waitLvl(0, 1'b1, 3 * WCYC);
    chk("clkFaultIdle", 0, clkFault);
    oscRun = 1'b0;
    waitLvl(3, 1'b1, 3 * TICK);
    repeat (3) @(negedge core_clk);
    chk("clkHoldOff", 0, holdOff);
  endtask : tClkFail

  initial
  begin
    errTotal = 0;
    samplesChecked = 0;
    reset_n = 1'b0;
    primeStrapPin = 1'b1;
    tickAck = 1'b0;
    punchMode = 2'h0;
    oscRun = 1'b1;
    foreach (rq[i])
    begin
      rq[i] = 1'b0;
      wr[i] = 1'b0;
      ad[i] = '0;
      wd[i] = '0;
    end
    doReset(1'b1);
    tClocks();
    tWindow();
    tMemories();
    tTrip(2'h2);
    tClkFail();
    doReset(1'b0);
    tTrip(2'h1);
    testDone();
  end
endmodule : tb
